/* File: hdl/cfs_pkg.sv */
// Constants, field layouts and carrier types for the clock-fail interrupt and sleep gating block.
// Assumes a 10 MHz system clock and a simple one-cycle register port.
//
// Operation
// - Set clock-fail flag whenever the fail-safe clock monitor reports a primary oscillator failure.
// - Flag sets regardless of interrupt enable or priority, so software can poll it.
// - With enable set each fail event requests an interrupt; enable clear means no request.
// - Three-bit priority, 7 highest down to 1; priority 0 never interrupts.
// - A higher priority group request preempts the interrupt being serviced.
// - Two-bit subpriority orders sources within a group, 3 highest, 0 lowest.
// - Same group, higher subpriority preempts an in-progress lower subpriority interrupt.
// - Equal priority and subpriority ties go to the lower vector number.
// - Losers of a tie are raised later, once the current flag is cleared.
// - Taken interrupt branches to its vector, equal to natural order; vectors may be shared.
// - Oscillator control register shows a clock-fail status bit at mask 0x0008.
// - Flag and enable at bit 14; priority from bit 10, subpriority from bit 8.
// - Primary oscillator always stops in Sleep; start-up delay applies on wake.
// - Secondary stops in Sleep unless enabled or used; delay only if it stopped.
// - Fast RC oscillator is stopped whenever the device sleeps.
// - Low-power RC stops in Sleep when the watchdog is disabled, else keeps running.
// - Idle stops no clock source and leaving Idle has no start-up delay.
// - Oscillator unit keeps operating normally in Debug mode.
// - Any reset restores control defaults and loads clock select and dividers from configuration.
// - After reset the system clock moves to the configured source, with start-up delays.
package cfs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFS_ADDR_OSC_CTRL = 8'h00;
  localparam logic [7:0] CFS_ADDR_FLAG = 8'h04;
  localparam logic [7:0] CFS_ADDR_ENABLE = 8'h08;
  localparam logic [7:0] CFS_ADDR_PRIO = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFS_OSC_SOSC_EN_BIT = 1;
  localparam int CFS_OSC_FAIL_BIT = 3;
  localparam int CFS_OSC_READY_BIT = 5;
  localparam int CFS_OSC_SEL_LSB = 12;
  localparam int CFS_OSC_PLLDIV_LSB = 16;
  localparam int CFS_OSC_UPLLDIV_LSB = 20;
  localparam int CFS_FAIL_BIT = 14;
  localparam int CFS_PRIO_LSB = 10;
  localparam int CFS_SUBPRIO_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CFS_SOSC_EN_RESET = 1'b0;
  localparam logic [2:0] CFS_PRIO_RESET = 3'h0;
  localparam logic [1:0] CFS_SUBPRIO_RESET = 2'h0;
  localparam logic [2:0] CFS_SEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Clock select codes, grouped by the oscillator they need
  // ----------------------------------------------------------------
  localparam logic [2:0] CFS_SEL_POSC = 3'h2;
  localparam logic [2:0] CFS_SEL_POSC_PLL = 3'h3;
  localparam logic [2:0] CFS_SEL_SOSC = 3'h4;
  localparam logic [2:0] CFS_SEL_LOW_POWER_RC_OSCILLATOR = 3'h5;

  // ----------------------------------------------------------------
  // Interrupt arbitration
  // ----------------------------------------------------------------
  localparam int CFS_EXT_SOURCES = 3;
  localparam logic [5:0] CFS_FAIL_VECTOR = 6'h06;
  localparam logic [2:0] CFS_PRIO_NONE = 3'h0;

  // ----------------------------------------------------------------
  // Start-up timing
  // ----------------------------------------------------------------
  localparam int CFS_CLK_PERIOD_NS = 100;
  localparam int CFS_POSC_START_US = 1000;
  localparam int CFS_SOSC_START_US = 10000;
  localparam int CFS_FRC_START_US = 2;
  localparam int CFS_LOW_POWER_RC_OSCILLATOR_START_US = 10;
  localparam int CFS_POSC_START_CYC = (CFS_POSC_START_US * 1000 + CFS_CLK_PERIOD_NS - 1) / CFS_CLK_PERIOD_NS;
  localparam int CFS_SOSC_START_CYC = (CFS_SOSC_START_US * 1000 + CFS_CLK_PERIOD_NS - 1) / CFS_CLK_PERIOD_NS;
  localparam int CFS_FRC_START_CYC = (CFS_FRC_START_US * 1000 + CFS_CLK_PERIOD_NS - 1) / CFS_CLK_PERIOD_NS;
  localparam int CFS_LOW_POWER_RC_OSCILLATOR_START_CYC = (CFS_LOW_POWER_RC_OSCILLATOR_START_US * 1000 + CFS_CLK_PERIOD_NS - 1) / CFS_CLK_PERIOD_NS;
  localparam int CFS_TIMER_W = 20;

  // Oscillator indexes
  localparam int CFS_OSC_POSC = 0;
  localparam int CFS_OSC_SOSC = 1;
  localparam int CFS_OSC_FRC = 2;
  localparam int CFS_OSC_LOW_POWER_RC_OSCILLATOR = 3;
  localparam int CFS_OSC_COUNT = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFS_MODE_RUN,
    CFS_MODE_IDLE,
    CFS_MODE_SLEEP
  } cfs_power_mode_t;

  typedef struct packed {
    logic valid;
    logic [2:0] priority_level;
    logic [1:0] subpriority;
    logic [5:0] vector;
  } cfs_req_t;

  typedef struct packed {
    logic active;
    logic [2:0] priority_level;
    logic [1:0] subpriority;
  } cfs_level_t;

  typedef struct packed {
    logic [2:0] current_clock_select;
  } cfs_cfg_one_t;

  typedef struct packed {
    logic [2:0] pll_input_divider;
    logic [2:0] usb_pll_input_divider;
  } cfs_cfg_two_t;

  typedef struct packed {
    logic posc;
    logic sosc;
    logic fast_rc_oscillator;
    logic low_power_rc_oscillator;
  } cfs_osc_t;

endpackage

/* File: hdl/cfs_start_timer.sv */
// Start-up delay counter for one oscillator.
// Assumes run is a registered enable; ready rises limit+1 cycles after run rises and drops one cycle after run drops.
`timescale 1ns/1ns

module cfs_start_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  input wire logic [cfs_pkg::CFS_TIMER_W-1:0] limit,
  // Status
  output logic ready
);

  logic [cfs_pkg::CFS_TIMER_W-1:0] count;

  // Counter restarts whenever the oscillator is stopped, so only a real stop costs a delay
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (!run) begin
      count <= '0;
    end else if (count != limit) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready <= 1'b0;
    end else begin
      ready <= run && (count == limit);
    end
  end

endmodule

/* File: hdl/cfs_top.sv */
// Clock-fail interrupt flag, enable, priority and arbitration, plus oscillator gating in
// Sleep, Idle and Debug and reload of clock selection from configuration words on reset.
// Assumes all inputs synchronous to sys_clk and a one-cycle register port.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns

module cfs_top #(
  parameter int POSC_START_CYCLES = cfs_pkg::CFS_POSC_START_CYC,
  parameter int SOSC_START_CYCLES = cfs_pkg::CFS_SOSC_START_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Fail-safe clock monitor
  input wire logic fail_event,
  // Power state
  input wire cfs_pkg::cfs_power_mode_t power_mode,
  input wire logic debug_mode,
  input wire logic watchdog_enable,
  input wire logic sosc_sleep_user,
  // Configuration words
  input wire cfs_pkg::cfs_cfg_one_t configuration_word_one,
  input wire cfs_pkg::cfs_cfg_two_t configuration_word_two,
  // Interrupt controller side
  input wire cfs_pkg::cfs_req_t [cfs_pkg::CFS_EXT_SOURCES-1:0] ext_req,
  input wire cfs_pkg::cfs_level_t in_service,
  output cfs_pkg::cfs_req_t irq_out,
  // Oscillator controls
  output cfs_pkg::cfs_osc_t osc_run,
  output logic sys_clk_ready,
  output logic [2:0] current_clock_select,
  output logic [2:0] pll_input_divider,
  output logic [2:0] usb_pll_input_divider
);

  localparam int NSRC = cfs_pkg::CFS_EXT_SOURCES + 1;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // a outranks b: group first, then subpriority, then lower vector
  function automatic logic outranks(input cfs_pkg::cfs_req_t a, input cfs_pkg::cfs_req_t b);
    if (!a.valid) begin
      return 1'b0;
    end
    if (!b.valid) begin
      return 1'b1;
    end
    if (a.priority_level != b.priority_level) begin
      return a.priority_level > b.priority_level;
    end
    if (a.subpriority != b.subpriority) begin
      return a.subpriority > b.subpriority;
    end
    return a.vector < b.vector;
  endfunction

  // Which oscillator a clock select code needs
  function automatic logic [1:0] osc_of(input logic [2:0] sel);
    case (sel)
      cfs_pkg::CFS_SEL_POSC, cfs_pkg::CFS_SEL_POSC_PLL: osc_of = 2'(cfs_pkg::CFS_OSC_POSC);
      cfs_pkg::CFS_SEL_SOSC: osc_of = 2'(cfs_pkg::CFS_OSC_SOSC);
      cfs_pkg::CFS_SEL_LOW_POWER_RC_OSCILLATOR: osc_of = 2'(cfs_pkg::CFS_OSC_LOW_POWER_RC_OSCILLATOR);
      default: osc_of = 2'(cfs_pkg::CFS_OSC_FRC);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_osc;
  logic wr_flag;
  logic wr_enable;
  logic wr_prio;

  assign wr_osc = reg_write && (reg_addr == cfs_pkg::CFS_ADDR_OSC_CTRL);
  assign wr_flag = reg_write && (reg_addr == cfs_pkg::CFS_ADDR_FLAG);
  assign wr_enable = reg_write && (reg_addr == cfs_pkg::CFS_ADDR_ENABLE);
  assign wr_prio = reg_write && (reg_addr == cfs_pkg::CFS_ADDR_PRIO);

  // ----------------------------------------------------------------
  // Clock-fail flag, status, enable and priority
  // ----------------------------------------------------------------
  logic clock_fail_irq_flag;
  logic clock_fail_irq_enable;
  logic clock_fail_status;
  logic [2:0] clock_fail_priority;
  logic [1:0] clock_fail_subpriority;
  logic secondary_osc_enable;

  // Set wins over a clear in the same cycle, so no failure is lost
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_fail_irq_flag <= 1'b0;
    end else if (fail_event) begin
      clock_fail_irq_flag <= 1'b1;
    end else if (wr_flag) begin
      clock_fail_irq_flag <= reg_wdata[cfs_pkg::CFS_FAIL_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_fail_status <= 1'b0;
    end else if (fail_event) begin
      clock_fail_status <= 1'b1;
    end else if (wr_osc && !reg_wdata[cfs_pkg::CFS_OSC_FAIL_BIT]) begin
      clock_fail_status <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_fail_irq_enable <= 1'b0;
    end else if (wr_enable) begin
      clock_fail_irq_enable <= reg_wdata[cfs_pkg::CFS_FAIL_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_fail_priority <= cfs_pkg::CFS_PRIO_RESET;
      clock_fail_subpriority <= cfs_pkg::CFS_SUBPRIO_RESET;
    end else if (wr_prio) begin
      clock_fail_priority <= reg_wdata[cfs_pkg::CFS_PRIO_LSB +: 3];
      clock_fail_subpriority <= reg_wdata[cfs_pkg::CFS_SUBPRIO_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      secondary_osc_enable <= cfs_pkg::CFS_SOSC_EN_RESET;
    end else if (wr_osc) begin
      secondary_osc_enable <= reg_wdata[cfs_pkg::CFS_OSC_SOSC_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Arbitration among the clock-fail source and the other sources
  // ----------------------------------------------------------------
  cfs_pkg::cfs_req_t cand [NSRC];
  cfs_pkg::cfs_req_t best;

  // Flag stays pending while masked off, so a loser is raised again later
  always_comb begin
    cand[0].valid = clock_fail_irq_flag && clock_fail_irq_enable
                    && (clock_fail_priority != cfs_pkg::CFS_PRIO_NONE);
    cand[0].priority_level = clock_fail_priority;
    cand[0].subpriority = clock_fail_subpriority;
    cand[0].vector = cfs_pkg::CFS_FAIL_VECTOR;
  end

  genvar gi;
  generate
    for (gi = 1; gi < NSRC; gi++) begin : g_ext
      always_comb begin
        cand[gi] = ext_req[gi-1];
        cand[gi].valid = ext_req[gi-1].valid
                         && (ext_req[gi-1].priority_level != cfs_pkg::CFS_PRIO_NONE);
      end
    end
  endgenerate

  always_comb begin
    best = cand[0];
    for (int i = 1; i < NSRC; i++) begin
      if (outranks(cand[i], best)) begin
        best = cand[i];
      end
    end
  end

  cfs_pkg::cfs_req_t serviced;
  logic preempts;

  // Only a strictly higher group, or higher subpriority in the same group, preempts
  always_comb begin
    serviced.valid = in_service.active;
    serviced.priority_level = in_service.priority_level;
    serviced.subpriority = in_service.subpriority;
    serviced.vector = '0;
    preempts = best.valid && (!in_service.active
               || (best.priority_level > in_service.priority_level)
               || ((best.priority_level == in_service.priority_level)
                   && (best.subpriority > in_service.subpriority)));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out <= '0;
    end else if (preempts && outranks(best, serviced)) begin
      irq_out <= best;
    end else begin
      irq_out <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration reload after reset
  // ----------------------------------------------------------------
  logic cfg_pending;

  // Configuration words are ports, so they are caught on the first edge after release
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_pending <= 1'b1;
    end else begin
      cfg_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      current_clock_select <= cfs_pkg::CFS_SEL_RESET;
      pll_input_divider <= '0;
      usb_pll_input_divider <= '0;
    end else if (cfg_pending) begin
      current_clock_select <= configuration_word_one.current_clock_select;
      pll_input_divider <= configuration_word_two.pll_input_divider;
      usb_pll_input_divider <= configuration_word_two.usb_pll_input_divider;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator gating
  // ----------------------------------------------------------------
  logic sleeping;
  logic [1:0] needed;
  cfs_pkg::cfs_osc_t next_osc_run;

  // Debug keeps everything as in Run; Idle gates nothing
  assign sleeping = (power_mode == cfs_pkg::CFS_MODE_SLEEP) && !debug_mode;
  assign needed = osc_of(current_clock_select);

  always_comb begin
    next_osc_run.posc = !sleeping && !cfg_pending
                        && (needed == 2'(cfs_pkg::CFS_OSC_POSC));
    next_osc_run.sosc = !cfg_pending && (secondary_osc_enable || sosc_sleep_user
                        || (!sleeping && (needed == 2'(cfs_pkg::CFS_OSC_SOSC))));
    next_osc_run.fast_rc_oscillator = !sleeping;
    next_osc_run.low_power_rc_oscillator = watchdog_enable
                        || (!sleeping && (needed == 2'(cfs_pkg::CFS_OSC_LOW_POWER_RC_OSCILLATOR)));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run <= '0;
    end else begin
      osc_run <= next_osc_run;
    end
  end

  // ----------------------------------------------------------------
  // Start-up delays
  // ----------------------------------------------------------------
  logic [cfs_pkg::CFS_OSC_COUNT-1:0] osc_bits;
  logic [cfs_pkg::CFS_OSC_COUNT-1:0] osc_ready;
  logic [cfs_pkg::CFS_TIMER_W-1:0] limits [cfs_pkg::CFS_OSC_COUNT];

  assign osc_bits[cfs_pkg::CFS_OSC_POSC] = osc_run.posc;
  assign osc_bits[cfs_pkg::CFS_OSC_SOSC] = osc_run.sosc;
  assign osc_bits[cfs_pkg::CFS_OSC_FRC] = osc_run.fast_rc_oscillator;
  assign osc_bits[cfs_pkg::CFS_OSC_LOW_POWER_RC_OSCILLATOR] = osc_run.low_power_rc_oscillator;
  assign limits[cfs_pkg::CFS_OSC_POSC] = cfs_pkg::CFS_TIMER_W'(POSC_START_CYCLES);
  assign limits[cfs_pkg::CFS_OSC_SOSC] = cfs_pkg::CFS_TIMER_W'(SOSC_START_CYCLES);
  assign limits[cfs_pkg::CFS_OSC_FRC] = cfs_pkg::CFS_TIMER_W'(cfs_pkg::CFS_FRC_START_CYC);
  assign limits[cfs_pkg::CFS_OSC_LOW_POWER_RC_OSCILLATOR] = cfs_pkg::CFS_TIMER_W'(cfs_pkg::CFS_LOW_POWER_RC_OSCILLATOR_START_CYC);

  // A running oscillator keeps its count, so waking from Idle costs nothing
  generate
    for (gi = 0; gi < cfs_pkg::CFS_OSC_COUNT; gi++) begin : g_timer
      cfs_start_timer u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(osc_bits[gi]),
        .limit(limits[gi]),
        .ready(osc_ready[gi])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_clk_ready <= 1'b0;
    end else begin
      sys_clk_ready <= osc_ready[needed] && !sleeping;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      cfs_pkg::CFS_ADDR_OSC_CTRL: begin
        next_rdata[cfs_pkg::CFS_OSC_SOSC_EN_BIT] = secondary_osc_enable;
        next_rdata[cfs_pkg::CFS_OSC_FAIL_BIT] = clock_fail_status;
        next_rdata[cfs_pkg::CFS_OSC_READY_BIT] = sys_clk_ready;
        next_rdata[cfs_pkg::CFS_OSC_SEL_LSB +: 3] = current_clock_select;
        next_rdata[cfs_pkg::CFS_OSC_PLLDIV_LSB +: 3] = pll_input_divider;
        next_rdata[cfs_pkg::CFS_OSC_UPLLDIV_LSB +: 3] = usb_pll_input_divider;
      end
      cfs_pkg::CFS_ADDR_FLAG: begin
        next_rdata[cfs_pkg::CFS_FAIL_BIT] = clock_fail_irq_flag;
      end
      cfs_pkg::CFS_ADDR_ENABLE: begin
        next_rdata[cfs_pkg::CFS_FAIL_BIT] = clock_fail_irq_enable;
      end
      cfs_pkg::CFS_ADDR_PRIO: begin
        next_rdata[cfs_pkg::CFS_PRIO_LSB +: 3] = clock_fail_priority;
        next_rdata[cfs_pkg::CFS_SUBPRIO_LSB +: 2] = clock_fail_subpriority;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

/* File: tb/cfs_checker.sv */
// Port assertions for cfs_top: read port, gating, reset load, arbitration.
// Assumes one clock domain; bound in at the foot of this file.
`timescale 1ns/1ns
module cfs_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Inputs
  input wire logic reg_read,
  input wire cfs_pkg::cfs_power_mode_t power_mode,
  input wire logic debug_mode,
  input wire logic watchdog_enable,
  input wire logic sosc_sleep_user,
  input wire cfs_pkg::cfs_cfg_one_t configuration_word_one,
  input wire cfs_pkg::cfs_level_t in_service,
  // Outputs
  input wire logic [31:0] reg_rdata,
  input wire cfs_pkg::cfs_req_t irq_out,
  input wire cfs_pkg::cfs_osc_t osc_run,
  input wire logic sys_clk_ready,
  input wire logic [2:0] current_clock_select
);
  // ------
  // Edges since reset
  // ------
  // Gating outputs lag reset release, so checks wait three edges
  logic [1:0] up;
  wire sl = power_mode == cfs_pkg::CFS_MODE_SLEEP && !debug_mode;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  rd_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not idle");
  frc_gate_a: assert property (up == 2'h3 |-> osc_run.fast_rc_oscillator == !$past(sl))
    else $error("fast rc gating wrong");
  posc_sleep_a: assert property (up == 2'h3 && $past(sl) |-> !osc_run.posc)
    else $error("primary runs in sleep");
  low_power_rc_oscillator_wdt_a: assert property (up == 2'h3 |-> osc_run.low_power_rc_oscillator == ($past(watchdog_enable) ||
    !$past(sl) && $past(current_clock_select) == cfs_pkg::CFS_SEL_LOW_POWER_RC_OSCILLATOR))
    else $error("low-power rc gating wrong");
  idle_run_a: assert property (up == 2'h3 && $past(power_mode) == cfs_pkg::CFS_MODE_IDLE |->
    osc_run.fast_rc_oscillator && osc_run.posc == ($past(current_clock_select[2:1]) == 2'h1))
    else $error("source stopped in idle");
  sosc_user_a: assert property (up == 2'h3 && $past(sosc_sleep_user) |-> osc_run.sosc)
    else $error("secondary stopped while used");
  cfg_load_a: assert property (up == 2'h1 |->
    current_clock_select == $past(configuration_word_one.current_clock_select))
    else $error("clock select not loaded");
  prio_zero_a: assert property (irq_out.valid |-> irq_out.priority_level != 3'h0)
    else $error("request at priority zero");
  preempt_a: assert property (irq_out.valid && $past(in_service.active) |->
    irq_out.priority_level > $past(in_service.priority_level) ||
    irq_out.priority_level == $past(in_service.priority_level) &&
    irq_out.subpriority > $past(in_service.subpriority))
    else $error("request does not preempt");
  ready_sleep_a: assert property ($past(sl) && $past(sl, 2) && $past(sl, 3) |-> !sys_clk_ready)
    else $error("clock ready in sleep");
endmodule
bind cfs_top cfs_checker u_chk (.sys_clk, .sys_rst, .reg_read, .power_mode, .debug_mode, .watchdog_enable,
  .sosc_sleep_user, .configuration_word_one, .in_service, .reg_rdata, .irq_out, .osc_run, .sys_clk_ready,
  .current_clock_select);

/* File: tb/cfs_cpu_model.sv */
// CPU side model: takes the winning request and serves it until done.
// Assumes take and done are one-cycle pulses from the bench.
`timescale 1ns/1ns
module cfs_cpu_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bench control
  input wire logic take,
  input wire logic done,
  // Block side
  input wire cfs_pkg::cfs_req_t irq_out,
  output cfs_pkg::cfs_level_t in_service,
  output logic [5:0] taken_vec
);
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_service <= '0;
      taken_vec <= 6'h0;
    end else if (take && irq_out.valid) begin
      // Branch to the winner's vector
      in_service <= {1'b1, irq_out.priority_level, irq_out.subpriority};
      taken_vec <= irq_out.vector;
    end else if (done) begin
      in_service.active <= 1'b0;
    end
  end
endmodule

/* File: tb/tb_cfs_top.sv */
// Bench for cfs_top: registers, fail interrupt, arbitration, gating, resets.
// Assumes the bound checker and cfs_cpu_model as the CPU.
`timescale 1ns/1ns
module tb_cfs_top;
  logic sys_clk = '0, sys_rst = '1, reg_write = '0, reg_read = '0, fail_event = '0, rd_d = '0;
  logic debug_mode = '0, watchdog_enable = '0, sosc_sleep_user = '0, take = '0, done = '0, sys_clk_ready;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, q[$];
  logic [2:0] current_clock_select, pll_input_divider, usb_pll_input_divider;
  logic [5:0] taken_vec;
  int errors = 0, num_checks = 0;
  cfs_pkg::cfs_power_mode_t power_mode = cfs_pkg::CFS_MODE_RUN;
  cfs_pkg::cfs_cfg_one_t configuration_word_one = cfs_pkg::CFS_SEL_POSC;
  cfs_pkg::cfs_cfg_two_t configuration_word_two = '0;
  cfs_pkg::cfs_req_t [2:0] ext_req = '0;
  cfs_pkg::cfs_req_t irq_out;
  cfs_pkg::cfs_level_t in_service;
  cfs_pkg::cfs_osc_t osc_run;
  always #50 sys_clk = ~sys_clk;
  cfs_top #(.POSC_START_CYCLES(20), .SOSC_START_CYCLES(30)) u_dut (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .fail_event, .power_mode, .debug_mode, .watchdog_enable,
    .sosc_sleep_user, .configuration_word_one, .configuration_word_two, .ext_req, .in_service, .irq_out,
    .osc_run, .sys_clk_ready, .current_clock_select, .pll_input_divider, .usb_pll_input_divider);
  cfs_cpu_model u_cpu (.sys_clk, .sys_rst, .take, .done, .irq_out, .in_service, .taken_vec);
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= '1;
    @(posedge sys_clk);
    reg_write <= '0;
  endtask
  // Expected read data queued here, checked by the monitor below
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= '1;
    q.push_back(e);
    @(posedge sys_clk);
    reg_read <= '0;
  endtask
  task automatic fe();
    @(posedge sys_clk);
    fail_event <= '1;
    @(posedge sys_clk);
    fail_event <= '0;
  endtask
  task automatic ex(logic [11:0] v, logic [11:0] e);
    @(posedge sys_clk);
    ext_req[0] <= v;
    settle();
    cmp({20'h0, irq_out}, {20'h0, e});
  endtask
  task automatic cpu(logic t, logic d);
    @(posedge sys_clk);
    take <= t;
    done <= d;
    @(posedge sys_clk);
    take <= '0;
    done <= '0;
  endtask
  task automatic pm(cfs_pkg::cfs_power_mode_t m, logic e);
    @(posedge sys_clk);
    power_mode <= m;
    debug_mode <= '0;
    settle();
    cmp({31'h0, sys_clk_ready}, {31'h0, e});
  endtask
  function automatic logic [31:0] ov(logic [5:0] lo);
    return {9'h0, configuration_word_two.usb_pll_input_divider, 1'b0, configuration_word_two.pll_input_divider,
      1'b0, configuration_word_one.current_clock_select, 6'h0, lo};
  endfunction
  always @(posedge sys_clk) begin
    if (rd_d) cmp(reg_rdata, q.pop_front());
    rd_d <= reg_read;
  end
  initial begin
    #600000;
    errors++;
    give_verdict();
  end
  // ------
  // Stimulus
  // ------
  initial begin
    void'($urandom(32'h04ab5d4a));
    configuration_word_two = 6'($urandom);
    // Priority zero bystander, must never win
    ext_req[1] = {4'h8, 8'($urandom)};
    repeat (16) @(posedge sys_clk);
    sys_rst <= '0;
    repeat (40) @(posedge sys_clk);
    rd(8'h00, ov(6'h20));
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    fe();
    fe();
    rd(8'h04, 32'h4000);
    rd(8'h00, ov(6'h28));
    ex(12'h0, 12'h0);
    wr(8'h08, 32'h4000);
    ex(12'h0, 12'h0);
    wr(8'h0c, 32'h1000);
    wr(8'h00, 32'h0);
    rd(8'h00, ov(6'h20));
    wr(8'h08, 32'h0);
    ex(12'h0, 12'h0);
    wr(8'h08, 32'h4000);
    ex(12'h0, 12'hc06);
    ex(12'hc08, 12'hc06);
    ex(12'hc02, 12'hc02);
    ex(12'hc48, 12'hc48);
    ex(12'h0, 12'hc06);
    cpu('1, '0);
    ex(12'h0, 12'h0);
    cmp({26'h0, taken_vec}, 32'h6);
    ex(12'hc49, 12'hc49);
    ex(12'hbc9, 12'h0);
    ex(12'hd09, 12'hd09);
    wr(8'h04, 32'h0);
    ex(12'h0, 12'h0);
    cpu('0, '1);
    for (int i = 0; i < 64; i++) begin
      wr(8'h00, {30'h0, i[4], 1'b0});
      @(posedge sys_clk);
      power_mode <= cfs_pkg::cfs_power_mode_t'({i[1], i[0] & ~i[1]});
      debug_mode <= i[2];
      watchdog_enable <= i[3];
      sosc_sleep_user <= i[5];
      settle();
      cmp({28'h0, osc_run}, {28'h0, ~i[1] | i[2], i[4] | i[5], ~i[1] | i[2], i[3]});
    end
    pm(cfs_pkg::CFS_MODE_SLEEP, '0);
    pm(cfs_pkg::CFS_MODE_RUN, '0);
    repeat (30) @(posedge sys_clk);
    pm(cfs_pkg::CFS_MODE_IDLE, '1);
    pm(cfs_pkg::CFS_MODE_RUN, '1);
    @(posedge sys_clk);
    configuration_word_one <= cfs_pkg::CFS_SEL_LOW_POWER_RC_OSCILLATOR;
    configuration_word_two <= 6'($urandom);
    sys_rst <= '1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= '0;
    repeat (50) @(posedge sys_clk);
    rd(8'h00, ov(6'h00));
    cmp({23'h0, current_clock_select, pll_input_divider, usb_pll_input_divider},
      {23'h0, configuration_word_one, configuration_word_two});
    repeat (100) @(posedge sys_clk);
    rd(8'h00, ov(6'h20));
    repeat (3) @(posedge sys_clk);
    give_verdict();
  end
endmodule
